// File: sim/lsm_asserts.sv
/* Link checker for both ends of the mode controller.
   Assumes one clock, active-low asynchronous reset. */
`timescale 1ns/10ps
module lsm_asserts #(parameter int WD_CYC = 40) (
    input wire logic mclk, arst_n, reset_pull_n, wd_kick, rx_data,
    input wire logic reset_out_n, wake_request, reg_valid, reg_ready
);
    logic [15:0] wd_cnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // slack of three covers the restart entry and the registered reset_out_n
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) wd_cnt <= 16'h0;
        else wd_cnt <= (reset_out_n && !wd_kick) ? wd_cnt + 16'h1 : 16'h0;
    end
    rst_wake_a: assert property (reset_out_n |-> wake_request)
        else $error("released asleep");
    rdy_pulse_a: assert property (reg_ready |=> !reg_ready)
        else $error("ready too long");
    rdy_ans_a: assert property (reg_valid && !reg_ready |=> reg_ready)
        else $error("no answer");
    rdy_cause_a: assert property (reg_ready |-> $past(reg_valid))
        else $error("stray ready");
    rx_idle_a: assert property (!reset_out_n && !$past(reset_out_n)
        |-> rx_data) else $error("rx active");
    hold_time_a: assert property ($rose(reset_out_n)
        |-> !$past(reset_out_n, 8)) else $error("hold short");
    ext_reset_a: assert property ($fell(reset_pull_n) && reset_out_n
        |-> ##[1:8] !reset_out_n) else $error("reset ignored");
    wd_limit_a: assert property (wd_cnt <= WD_CYC + 3)
        else $error("watchdog late");
endmodule : lsm_asserts

// File: sim/tb_top.sv
/* Bench: both ends on one link, orders over AXI4-Lite.
   Assumes the package, link interface and both design ends. */
`timescale 1ns/10ps
module tb_top;
    import lsm_pkg::*;
    logic mclk, arst_n, control_select_pin, supply_brownout, wake_pin;
    logic supply_undervoltage, regulator_undervoltage, regulator_short;
    logic regulator_overvoltage, thermal_shutdown, lin_bus_in, lin_bus_out;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    lsm_mode_t mode_state;
    int n_errors, comparisons;
    logic [10:0] rows [6] = '{{8'h80, st_normal}, {8'hC0, st_fast},
        {8'h00, st_standby}, {8'hC0, st_fast}, {8'h80, st_normal},
        {8'h40, st_sleep}};
    lsm_link_if lnk ();
    lsm_device #(.REG_ON_CYC(8), .HOLD_CYC(8), .FC_CYC(4), .FP_CYC(2),
        .EN_CYC(3), .WD_CYC(200), .GUARD_CYC(60)) lsm_device_inst (.*);
    lsm_host lsm_host_inst (.*);
    lsm_asserts #(.WD_CYC(200)) lsm_asserts_inst (.mclk, .arst_n,
        .reset_pull_n(lnk.reset_pull_n), .wd_kick(lnk.wd_kick),
        .rx_data(lnk.rx_data), .reset_out_n(lnk.reset_out_n),
        .wake_request(lnk.wake_request), .reg_valid(lnk.reg_valid),
        .reg_ready(lnk.reg_ready));
    initial begin mclk = 1'b0; forever #2 mclk = ~mclk; end
    task automatic chk(input string n, input logic [31:0] e, s);
        comparisons++;
        if (s !== e) begin
            $display("MISMATCH %s exp %h got %h", n, e, s);
            n_errors++;
        end
    endtask : chk
    task automatic wm(input lsm_mode_t e);
        for (int t = 0; t < 400 && mode_state !== e; t++) @(posedge mclk);
        chk("mode", e, mode_state);
    endtask : wm
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        {s_axi_awaddr, s_axi_wdata} <= {a, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge mclk); while (s_axi_awready !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask : rd
    // busy bit polled, so the read byte is the finished one
    task automatic drd(input logic [7:0] a);
        wr(12'h004, {16'h0, a, 8'h00});
        do rd(12'h008); while (d[0] !== 1'b0);
    endtask : drd
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin #100000; n_errors++; complete_run(); end
    initial begin
        {n_errors, comparisons, arst_n, s_axi_wstrb} = {64'h0, 1'b0, 4'hF};
        {control_select_pin, lin_bus_in, wake_pin, supply_brownout} = 4'hC;
        {supply_undervoltage, regulator_undervoltage, regulator_short} = 0;
        {regulator_overvoltage, thermal_shutdown, s_axi_awvalid} = 0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        repeat (2) @(posedge mclk);
        chk("mode", st_por, mode_state);
        arst_n <= 1'b1;
        wm(st_restart);
        wm(st_standby);
        drd(8'h28);
        chk("count", 1, d[15:8]);
        chk("rst_out", 1, lnk.reset_out_n);
        lin_bus_in <= 1'b0;
        foreach (rows[i]) begin
            wr(12'h000, 32'h9);
            wr(12'h004, {15'h0, 1'b1, 8'h1D, rows[i][10:3]});
            wm(lsm_mode_t'(rows[i][2:0]));
            repeat (6) @(posedge mclk);
            chk("rx", rows[i][2:1] != 2'b10, lnk.rx_data);
            chk("lin_out", rows[i][2:1] != 2'b10, lin_bus_out);
        end
        lin_bus_in <= 1'b1;
        repeat (8) @(posedge mclk);
        lin_bus_in <= 1'b0;
        wm(st_restart);
        wm(st_standby);
        wr(12'h000, 32'hB);
        wr(12'h004, 32'h11D80);
        wm(st_normal);
        regulator_short <= 1'b1;
        wm(st_failsafe);
        wake_pin <= 1'b1;
        wm(st_restart);
        wm(st_sleep);
        {regulator_short, wake_pin} <= 2'h0;
        wm(st_standby);
        rd(12'h010);
        chk("resp", 2, r);
        s_axi_wstrb <= 4'hE;
        wr(12'h000, 32'hE);
        s_axi_wstrb <= 4'hF;
        rd(12'h000);
        chk("ctrl", 32'h3, d);
        wr(12'h000, 32'hB);
        wr(12'h004, 32'h1280F);
        supply_undervoltage <= 1'b1;
        wm(st_failsafe);
        wr(12'h004, 32'h12800);
        {supply_undervoltage, wake_pin} <= 2'h1;
        wm(st_standby);
        wr(12'h004, 32'h11D02);
        thermal_shutdown <= 1'b1;
        wm(st_sleep);
        {thermal_shutdown, regulator_undervoltage, wake_pin} <= 3'h2;
        wm(st_restart);
        wm(st_sleep);
        {regulator_undervoltage, wake_pin} <= 2'h1;
        wm(st_standby);
        wr(12'h000, 32'hA);
        {control_select_pin, supply_brownout, regulator_overvoltage} <= 3'h3;
        wm(st_por);
        supply_brownout <= 1'b0;
        wm(st_failsafe);
        {regulator_overvoltage, wake_pin} <= 2'h0;
        wm(st_standby);
        wr(12'h004, 32'h11D80);
        drd(8'h1D);
        chk("pin_rd", 0, d[15:8]);
        chk("mode", st_standby, mode_state);
        wr(12'h000, 32'hB);
        wm(st_normal);
        wr(12'h000, 32'hA);
        wm(st_standby);
        wr(12'h000, 32'h8);
        wr(12'h000, 32'hB);
        wm(st_fast);
        wr(12'h000, 32'h8);
        wm(st_sleep);
        wr(12'h000, 32'h9);
        wm(st_restart);
        wm(st_standby);
        wm(st_restart);
        wm(st_standby);
        wr(12'h000, 32'h6);
        wm(st_restart);
        complete_run();
    end
endmodule : tb_top

// File: src/lsm_device.sv
/*
  Mode state machine of the LIN system-basis device end.
  Assumes analog monitors and LIN/wake pins arrive asynchronously,
  and the host end shares mclk.
*/
`timescale 1ns/10ps
`include "lsm_params.svh"
module lsm_device
    import lsm_pkg::*;
#(
    parameter int CW            = 16,
    parameter int REG_ON_CYC    =
        (`LSM_REG_ON_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
    parameter int HOLD_CYC      =
        (`LSM_RESTART_HOLD_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
    parameter int FC_CYC        =
        (`LSM_FAST_CHANGE_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
    parameter int FP_CYC        =
        (`LSM_FAST_PULSE_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
    parameter int EN_CYC        =
        (`LSM_EN_TIME_NS + `LSM_CLK_NS - 1) / `LSM_CLK_NS,
    parameter int WD_CYC        = `LSM_INIT_WD_NS / `LSM_CLK_NS,
    parameter int GUARD_CYC     = `LSM_WAKE_GUARD_NS / `LSM_CLK_NS,
    parameter int RESTART_LIMIT = `LSM_RESTART_LIMIT
) (
    input  wire logic     mclk,
    input  wire logic     arst_n,
    lsm_link_if.dev       lnk,
    input  wire logic     control_select_pin,
    input  wire logic     supply_undervoltage,
    input  wire logic     supply_brownout,
    input  wire logic     regulator_undervoltage,
    input  wire logic     regulator_overvoltage,
    input  wire logic     thermal_shutdown,
    input  wire logic     regulator_short,
    input  wire logic     lin_bus_in,
    input  wire logic     wake_pin,
    output logic          lin_bus_out,
    output lsm_mode_t     mode_state
);
    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (CW < 8 || CW > 24 || REG_ON_CYC < 3 || HOLD_CYC < 1 ||
        FC_CYC < 1 || FP_CYC < 1 || EN_CYC < 1 || WD_CYC < 1 ||
        GUARD_CYC < 1 || RESTART_LIMIT < 1 || RESTART_LIMIT > 255 ||
        REG_ON_CYC >= 2**CW || HOLD_CYC >= 2**CW || WD_CYC >= 2**CW ||
        GUARD_CYC >= 2**CW || FC_CYC >= 2**CW || EN_CYC >= 2**CW) begin : g_chk
        $error("lsm_device: parameter out of range");
    end

    localparam logic [CW-1:0] L_REG_ON = CW'(REG_ON_CYC);
    localparam logic [CW-1:0] L_HOLD   = CW'(HOLD_CYC);
    localparam logic [CW-1:0] L_FC     = CW'(FC_CYC);
    localparam logic [CW-1:0] L_FP     = CW'(FP_CYC);
    localparam logic [CW-1:0] L_EN     = CW'(EN_CYC);
    localparam logic [CW-1:0] L_WD     = CW'(WD_CYC);
    localparam logic [CW-1:0] L_GUARD  = CW'(GUARD_CYC);
    localparam logic [7:0]    L_RLIM   = 8'(RESTART_LIMIT);

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        return (&v) ? v : v + 1'b1;
    endfunction : sat_inc

    // ----------------------------------------------------------------
    // input synchronisers: three stages, change once stages 2 and 3 agree
    // ----------------------------------------------------------------
    logic [8:0] raw, s1, s2, s3, flt, flt_q;
    wire  [8:0] next_flt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & flt);
    assign raw = {wake_pin, lin_bus_in, regulator_short, thermal_shutdown,
                  regulator_overvoltage, regulator_undervoltage,
                  supply_brownout, supply_undervoltage, control_select_pin};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1    <= `LSM_SYNC_RST;
            s2    <= `LSM_SYNC_RST;
            s3    <= `LSM_SYNC_RST;
            flt   <= `LSM_SYNC_RST;
            flt_q <= `LSM_SYNC_RST;
        end else begin
            s1    <= raw;
            s2    <= s1;
            s3    <= s2;
            flt   <= next_flt;
            flt_q <= flt;
        end
    end

    wire sel_hi    = flt[0];
    wire sup_uv    = flt[1];
    wire brownout  = flt[2];
    wire reg_ov    = flt[4];
    wire reg_fault = |flt[6:3];
    wire lin_fall  = flt_q[7] & ~flt[7];
    wire wake_chg  = flt_q[8] ^ flt[8];

    // ----------------------------------------------------------------
    // state, timers and counters
    // ----------------------------------------------------------------
    lsm_mode_t     next_state;
    logic          spi_mode, guard_on, pulse_ok, kick_q, fs_dis;
    logic [1:0]    link_mode;
    logic [2:0]    code_q;
    logic [7:0]    rcnt;
    logic [CW-1:0] tmr, hold_cnt, txl_cnt, guard_cnt, wd_cnt;

    wire [2:0] code     = {lnk.mode_request, lnk.tx_data, lnk.reset_pull_n};
    wire       active   = mode_state == st_standby ||
                          mode_state == st_normal || mode_state == st_fast;
    wire       link_on  = mode_state == st_normal || mode_state == st_fast;
    wire       held_fc  = code == code_q && hold_cnt > L_FC;
    wire       held_fcm = code == code_q && hold_cnt >= L_FC;
    wire       held_en  = code == code_q && hold_cnt >= L_EN;
    wire       kick     = lnk.wd_kick & ~kick_q;
    wire       wd_fail  = active && wd_cnt >= L_WD;
    wire       guard_x  = guard_on && guard_cnt >= L_GUARD;
    wire       tx_rise  = lnk.tx_data & ~code_q[1];

    // register port: pin control answers but never accepts writes
    wire       reg_take = lnk.reg_valid & ~lnk.reg_ready;
    wire       reg_wr   = reg_take & lnk.reg_write & spi_mode;
    wire       wr_lc    = reg_wr && lnk.reg_addr == `LSM_LINK_CONTROL;
    wire       wr_rc    = reg_wr && lnk.reg_addr == `LSM_RESTART_COUNTER;
    wire [1:0] wr_mode  = lnk.reg_wdata[`LSM_MODE_HI:`LSM_MODE_LO];
    wire       soft_rst = wr_lc & lnk.reg_wdata[`LSM_SOFT_RST_BIT];
    wire [7:0] rd_val   =
        !spi_mode ? '0 :
        lnk.reg_addr == `LSM_LINK_CONTROL ?
            {link_mode, 4'h0, fs_dis, 1'b0} :
        lnk.reg_addr == `LSM_RESTART_COUNTER ? rcnt : '0;

    wire ext_rst  = ~lnk.reset_pull_n;
    wire rst_evt  = sup_uv | ext_rst | wd_fail | (spi_mode & soft_rst);
    wire wake_evt = lin_fall | wake_chg |
                    (~spi_mode & lnk.mode_request & held_fc);
    // too many restarts force fail-safe instead
    wire lsm_mode_t rst_tgt =
        (spi_mode && rcnt >= L_RLIM) ? st_failsafe : st_restart;
    wire lsm_mode_t flt_tgt =
        (spi_mode && fs_dis) ? st_sleep : st_failsafe;
    wire rst_entry = next_state == st_restart &&
                     mode_state != st_restart;

    // ----------------------------------------------------------------
    // next mode
    // ----------------------------------------------------------------
    always_comb begin
        next_state = mode_state;
        case (mode_state)
            st_por: begin
                if (tmr >= L_REG_ON)
                    next_state = (flt[6] | reg_ov) ? st_failsafe : st_init;
            end
            st_init: begin
                next_state = rst_tgt;
            end
            st_restart: begin
                if (guard_x)
                    next_state = st_sleep;
                else if (tmr >= L_HOLD && !(guard_on && reg_fault))
                    next_state = st_standby;
            end
            st_standby, st_normal, st_fast: begin
                if (rst_evt)
                    next_state = rst_tgt;
                else if (reg_fault)
                    next_state = flt_tgt;
                else if (spi_mode) begin
                    if (wr_lc) begin
                        case (wr_mode)
                            `LSM_MODE_STANDBY: next_state = st_standby;
                            `LSM_MODE_SLEEP:   next_state = st_sleep;
                            `LSM_MODE_NORMAL:  next_state = st_normal;
                            default:           next_state = st_fast;
                        endcase
                    end
                end else if (mode_state == st_standby) begin
                    if (code == 3'b111 && held_fc)
                        next_state = pulse_ok ? st_fast : st_normal;
                end else if (code == 3'b001 && held_en)
                    next_state = st_sleep;
                else if (code == 3'b011 && held_fcm)
                    next_state = st_standby;
            end
            st_sleep, st_failsafe: begin
                if (wake_evt)
                    next_state = rst_tgt;
            end
            default: next_state = st_por;
        endcase
        if (brownout)
            next_state = st_por;
    end

    // ----------------------------------------------------------------
    // clocked state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mode_state <= st_por;
            spi_mode   <= 1'b1;
            tmr        <= '0;
            guard_on   <= 1'b0;
            guard_cnt  <= '0;
        end else begin
            mode_state <= next_state;
            tmr        <= next_state != mode_state ? '0 : sat_inc(tmr);
            if (mode_state == st_por)
                spi_mode <= sel_hi;
            if (rst_entry)
                guard_on <= mode_state == st_sleep ||
                            mode_state == st_failsafe;
            else if (next_state != st_restart)
                guard_on <= 1'b0;
            guard_cnt  <= (guard_on && !rst_entry) ? sat_inc(guard_cnt) : '0;
        end
    end

    // pin pattern hold and fast-entry transmit pulse
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            code_q   <= '0;
            hold_cnt <= '0;
            txl_cnt  <= '0;
            pulse_ok <= 1'b0;
        end else begin
            code_q   <= code;
            hold_cnt <= code != code_q ? '0 : sat_inc(hold_cnt);
            txl_cnt  <= lnk.tx_data ? '0 : sat_inc(txl_cnt);
            if (mode_state != st_standby)
                pulse_ok <= 1'b0;
            else if (tx_rise && txl_cnt >= L_FP)
                pulse_ok <= 1'b1;
        end
    end

    // watchdog: window restarts on a kick or on any mode change
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kick_q <= 1'b0;
            wd_cnt <= '0;
        end else begin
            kick_q <= lnk.wd_kick;
            wd_cnt <= (!active || kick || mode_state != next_state) ?
                      '0 : sat_inc(wd_cnt);
        end
    end

    // registers; a counter bump in the cycle of a host write still lands
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link_mode     <= `LSM_MODE_STANDBY;
            fs_dis        <= 1'b0;
            rcnt          <= '0;
            lnk.reg_ready <= 1'b0;
            lnk.reg_rdata <= '0;
        end else begin
            if (wr_lc) begin
                link_mode <= wr_mode;
                fs_dis    <= lnk.reg_wdata[`LSM_FS_DIS_BIT];
            end
            if (brownout)
                rcnt <= '0;
            else
                rcnt <= 8'((wr_rc ? lnk.reg_wdata : rcnt) +
                           {7'h0, rst_entry & spi_mode});
            lnk.reg_ready <= reg_take;
            if (reg_take)
                lnk.reg_rdata <= rd_val;
        end
    end

    // ----------------------------------------------------------------
    // pin outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lin_bus_out      <= 1'b1;
            lnk.rx_data      <= 1'b1;
            lnk.reset_out_n  <= 1'b0;
            lnk.wake_request <= 1'b0;
        end else begin
            lin_bus_out      <= link_on ? lnk.tx_data : 1'b1;
            lnk.rx_data      <= link_on ? flt[7] : 1'b1;
            lnk.reset_out_n  <= active;
            lnk.wake_request <= mode_state != st_sleep &&
                                mode_state != st_failsafe &&
                                mode_state != st_por;
        end
    end
endmodule : lsm_device

// File: src/lsm_host.sv
/*
  Host end: drives mode pins and the byte register port of the
  device on orders written over AXI4-Lite.
  Assumes the device end shares mclk; no synchronisers needed.
*/
`timescale 1ns/10ps
`include "lsm_params.svh"
module lsm_host
    import lsm_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          mclk,
    input  wire logic          arst_n,
    lsm_link_if.host           lnk,
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);
    if (AW < 4 || AW > 32) begin : g_chk
        $error("lsm_host: AW out of range");
    end

    function automatic logic [1:0] resp_of(input logic [AW-1:0] a);
        return (a == AW'(`LSM_H_CTRL) || a == AW'(`LSM_H_CMD) ||
                a == AW'(`LSM_H_STAT)) ? `LSM_RESP_OK : `LSM_RESP_ERR;
    endfunction : resp_of

    logic [7:0]  last_rd;
    wire         busy   = lnk.reg_valid;
    wire         wr_go  = s_axi_awvalid & s_axi_awready &
                          s_axi_wvalid & s_axi_wready;
    wire         rd_go  = s_axi_arvalid & s_axi_arready;
    wire         wr_ctl = wr_go && s_axi_awaddr == AW'(`LSM_H_CTRL) &&
                          s_axi_wstrb[0];
    // a command while one is under way is dropped, not queued
    wire         wr_cmd = wr_go && s_axi_awaddr == AW'(`LSM_H_CMD) &&
                          &s_axi_wstrb[2:0] && !busy;
    wire [31:0]  stat   = {16'h0, last_rd, 4'h0, lnk.wake_request,
                           lnk.reset_out_n, lnk.rx_data, busy};
    wire [31:0]  ctl_rd = {28'h0, 1'b0, ~lnk.reset_pull_n,
                           lnk.tx_data, lnk.mode_request};
    wire [31:0]  rd_val =
        s_axi_araddr == AW'(`LSM_H_CTRL) ? ctl_rd :
        s_axi_araddr == AW'(`LSM_H_STAT) ? stat   : '0;

    // ----------------------------------------------------------------
    // AXI4-Lite slave: address and data taken together
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `LSM_RESP_OK;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `LSM_RESP_OK;
            s_axi_rdata   <= '0;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid &
                             ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid & s_axi_wvalid &
                             ~s_axi_awready & ~s_axi_bvalid;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= resp_of(s_axi_awaddr);
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= resp_of(s_axi_araddr);
                s_axi_rdata  <= rd_val;
            end else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pins toward the device
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            {lnk.reset_pull_n, lnk.tx_data, lnk.mode_request} <= `LSM_PIN_RST;
            lnk.wd_kick   <= 1'b0;
            lnk.reg_valid <= 1'b0;
            lnk.reg_write <= 1'b0;
            lnk.reg_addr  <= '0;
            lnk.reg_wdata <= '0;
            last_rd       <= '0;
        end else begin
            if (wr_ctl) begin
                lnk.mode_request <= s_axi_wdata[0];
                lnk.tx_data      <= s_axi_wdata[1];
                lnk.reset_pull_n <= ~s_axi_wdata[2];
            end
            lnk.wd_kick <= wr_ctl & s_axi_wdata[3];
            if (wr_cmd) begin
                lnk.reg_valid <= 1'b1;
                lnk.reg_wdata <= s_axi_wdata[7:0];
                lnk.reg_addr  <= s_axi_wdata[15:8];
                lnk.reg_write <= s_axi_wdata[16];
            end else if (lnk.reg_ready) begin
                lnk.reg_valid <= 1'b0;
                last_rd       <= lnk.reg_rdata;
            end
        end
    end
endmodule : lsm_host

// File: src/lsm_link_if.sv
/*
  Pins between the mode controller and its host: mode pins,
  LIN data, reset, watchdog kick and a byte register port.
  Assumes both ends share mclk.
*/
`timescale 1ns/10ps
interface lsm_link_if;
    logic       mode_request;
    logic       tx_data;
    logic       reset_pull_n;
    logic       wd_kick;
    logic       rx_data;
    logic       reset_out_n;
    logic       wake_request;
    logic       reg_valid;
    logic       reg_write;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_ready;
    logic [7:0] reg_rdata;
    modport dev (
        input  mode_request, tx_data, reset_pull_n, wd_kick,
        input  reg_valid, reg_write, reg_addr, reg_wdata,
        output rx_data, reset_out_n, wake_request, reg_ready, reg_rdata
    );
    modport host (
        output mode_request, tx_data, reset_pull_n, wd_kick,
        output reg_valid, reg_write, reg_addr, reg_wdata,
        input  rx_data, reset_out_n, wake_request, reg_ready, reg_rdata
    );
endinterface : lsm_link_if

// File: src/lsm_params.svh
/*
  Constants of the LIN mode controller pair: times, offsets, fields.
  Assumes a 250 MHz mclk; included by the device and host ends.
*/
// Functional notes
// - pin control ignores register port writes
// - select pin high or open selects register control
// - normal only via INIT, restart, standby
// - at regulator-on expiry check short and overvoltage
// - startup restart lasts the hold time, then standby
// - wake restart runs guard timer, expiry gives sleep
// - standby releases reset, starts watchdog, host kicks
// - host holds request, transmit, reset high for normal
// - normal and fast pass transmit and receive data
// - host holds request, transmit low for sleep
// - host holds request low, transmit high for standby
// - pin faults: restart or fail-safe
// - host transmit low pulse then request for fast
// - pin sleep wakes on bus, wake pin, request
// - wake restart needs standby and clean faults
// - fail-safe leaves only on wake, to restart
// - restart counter counts entries, host clears it
// - host writes normal code into link mode field
// - mode field codes standby, sleep, normal, fast
// - register faults: restart, fail-safe or sleep
// - fast code enters fast from standby or normal
// - control scheme fixed until power-on reset
// - brownout repeats the whole power-up
`ifndef LSM_PARAMS_SVH
`define LSM_PARAMS_SVH
`define LSM_CLK_NS          4
`define LSM_REG_ON_NS       4000
`define LSM_RESTART_HOLD_NS 8000
`define LSM_FAST_CHANGE_NS  2000
`define LSM_FAST_PULSE_NS   400
`define LSM_EN_TIME_NS      1000
`define LSM_INIT_WD_NS      16000
`define LSM_WAKE_GUARD_NS   40000
`define LSM_RESTART_LIMIT   15
`define LSM_LINK_CONTROL    8'h1D
`define LSM_RESTART_COUNTER 8'h28
`define LSM_MODE_HI         7
`define LSM_MODE_LO         6
`define LSM_SOFT_RST_BIT    0
`define LSM_FS_DIS_BIT      1
`define LSM_MODE_STANDBY    2'h0
`define LSM_MODE_SLEEP      2'h1
`define LSM_MODE_NORMAL     2'h2
`define LSM_MODE_FAST       2'h3
`define LSM_SYNC_RST        9'h081
`define LSM_H_CTRL          12'h000
`define LSM_H_CMD           12'h004
`define LSM_H_STAT          12'h008
`define LSM_CTRL_RST        4'h2
`define LSM_PIN_RST         3'h6
`define LSM_RESP_OK         2'h0
`define LSM_RESP_ERR        2'h2
`endif

// File: src/lsm_pkg.sv
/*
  Types shared by both ends of the LIN mode controller.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lsm_pkg;
    typedef enum logic [2:0] {
        st_por, st_init, st_restart, st_standby,
        st_normal, st_fast, st_sleep, st_failsafe
    } lsm_mode_t;
endpackage : lsm_pkg
